// File: rtl/adcseq_pkg.sv
// constants, types and state encodings for the converter cycle sequencer
// assumes a single 250 MHz core clock; pins arrive asynchronous to it
package adcseq_pkg;

	// ************************************************************
	// word layout
	// ************************************************************
	localparam int OUT_BITS = 32;
	localparam int CFG_BITS = 13;
	localparam int RES_BITS = 24;
	localparam int SUB_BITS = 5;
	localparam logic EOC_DONE = 1'b0;
	localparam logic CONSTANT_ZERO_BIT = 1'b0;
	localparam logic [OUT_BITS-1:0] WORD_OVER = 32'h30000000;
	localparam logic [OUT_BITS-1:0] WORD_UNDER = 32'h0fffffff;
	// channel 0 positive, channel 1 negative, 50/60 Hz, 1x
	localparam logic [CFG_BITS-1:0] CFG_DEFAULT = 13'h0000;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 250_000_000;
	localparam int INT_OSC_HZ = 307_200;
	localparam int INT_OSC_DIV = CLK_HZ / INT_OSC_HZ;
	localparam int OSC_IDLE_CYCLES = 4 * INT_OSC_DIV;
	localparam int POR_TIME_US = 4000;
	localparam int POR_CYCLES = POR_TIME_US * (CLK_HZ / 1_000_000);
	localparam int CONV_TICKS_DEF = 1024;
	localparam int ISCK_HALF_CYCLES = 20;
	localparam int FIFO_DEPTH = 4;

	// ************************************************************
	// synchroniser lanes
	// ************************************************************
	localparam int SY_CS = 0;
	localparam int SY_SCK = 1;
	localparam int SY_SDI = 2;
	localparam int SY_F0 = 3;
	localparam int SY_SUP = 4;
	localparam int SY_N = 5;
	localparam logic [SY_N-1:0] SYNC_INIT = 5'h03;

	typedef enum logic [1:0] {ST_POR, ST_CONV, ST_SLEEP, ST_IO} adcseq_state_t;
	typedef enum logic [1:0] {PH_OFFSET, PH_FULLSCALE, PH_SIGNAL} adcseq_phase_t;

endpackage // adcseq_pkg

// File: rtl/adcseq_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes both sides on the same clock
module adcseq_fifo
	import adcseq_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             srst_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic             push, pop;

	assign in_ready_out  = cnt_q != CW'(DEPTH);
	assign out_valid_out = cnt_q != '0;
	assign out_data_out  = mem_q[rd_q];

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop  = out_valid_out && out_ready_in;
		wr_d = push ? PW'((wr_q + 1'b1) % DEPTH) : wr_q;
		rd_d = pop ? PW'((rd_q + 1'b1) % DEPTH) : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

endmodule // adcseq_fifo

// File: rtl/adcseq_top.sv
// converter cycle sequencer: conversion, sleep, serial input/output
// assumes analog front end on clk_in; serial pins and f0 asynchronous
module adcseq_top
	import adcseq_pkg::*;
#(
	parameter int POR_CYCLES_P = POR_CYCLES,
	parameter int CONV_TICKS_P = CONV_TICKS_DEF
) (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         srst_in,
	// serial interface
	input  wire logic                         cs_n_in,
	input  wire logic                         sck_in,
	output logic                              sck_out,
	output logic                              sck_oe_out,
	input  wire logic                         sdi_in,
	output logic                              sdo_out,
	output logic                              sdo_oe_out,
	// conversion clock and supply monitor
	input  wire logic                         conversion_clock_select_in,
	input  wire logic                         supply_low_in,
	// analog front end
	input  wire logic                         afe_sign_in,
	input  wire logic [RES_BITS+SUB_BITS-1:0] afe_value_in,
	input  wire logic                         afe_over_in,
	input  wire logic                         afe_under_in,
	output logic      [CFG_BITS-1:0]          afe_cfg_out,
	output logic      [1:0]                   afe_phase_out
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [SY_N-1:0] pin_raw, meta_q, sync_q, prev_q;
	assign pin_raw = {supply_low_in, conversion_clock_select_in, sdi_in, sck_in, cs_n_in};

	for (genvar gi = 0; gi < SY_N; gi++) begin : g_sync
		always_ff @(posedge clk_in) begin
			if (srst_in) begin
				meta_q[gi] <= SYNC_INIT[gi];
				sync_q[gi] <= SYNC_INIT[gi];
				prev_q[gi] <= SYNC_INIT[gi];
			end else begin
				meta_q[gi] <= pin_raw[gi];
				sync_q[gi] <= meta_q[gi];
				prev_q[gi] <= sync_q[gi];
			end
		end
	end

	logic cs_n_s, sck_s, sdi_s, sup_s, cs_rise, cs_fall, f0_rise, sck_p;
	assign cs_n_s  = sync_q[SY_CS];
	assign sck_s   = sync_q[SY_SCK];
	assign sck_p   = prev_q[SY_SCK];
	assign sdi_s   = sync_q[SY_SDI];
	assign sup_s   = sync_q[SY_SUP];
	assign cs_rise = cs_n_s && !prev_q[SY_CS];
	assign cs_fall = !cs_n_s && prev_q[SY_CS];
	assign f0_rise = sync_q[SY_F0] && !prev_q[SY_F0];

	// ************************************************************
	// result word and fifo
	// ************************************************************
	logic [OUT_BITS-1:0] conv_word, fifo_data;
	logic                fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic                fifo_clr;

	// a low supply also flushes a word caught between push and pop
	assign fifo_clr = srst_in || sup_s;

	// over/underrange replace the value with distinct clamp codes
	assign conv_word = afe_over_in ? WORD_OVER :
		afe_under_in ? WORD_UNDER :
		{EOC_DONE, CONSTANT_ZERO_BIT, afe_sign_in, afe_value_in};

	adcseq_fifo #(
		.WIDTH (OUT_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.srst_in       (fifo_clr),
		.in_valid_in   (fifo_in_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (conv_word),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_data)
	);

	// ************************************************************
	// sequencer state
	// ************************************************************
	adcseq_state_t       st_q, st_d;
	logic [19:0]         por_cnt_q, por_cnt_d;
	logic [15:0]         conv_cnt_q, conv_cnt_d;
	logic [11:0]         osc_cnt_q, osc_cnt_d, idle_cnt_q, idle_cnt_d;
	logic                ext_osc_q, ext_osc_d, ext_sck_q, ext_sck_d, loaded_q, loaded_d;
	logic [5:0]          rise_cnt_q, rise_cnt_d;
	logic [4:0]          isck_cnt_q, isck_cnt_d;
	logic [OUT_BITS-1:0] shift_q, shift_d;
	logic [CFG_BITS-1:0] cfg_sr_q, cfg_sr_d, cfg_q, cfg_d;
	logic                sck_q, sck_d, sck_oe_q, sck_oe_d, sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
	logic [1:0]          phase_q, phase_d;
	logic                conv_tick, sck_rise, sck_fall;

	always_comb begin
		st_d = st_q;
		por_cnt_d = por_cnt_q;
		conv_cnt_d = conv_cnt_q;
		osc_cnt_d = osc_cnt_q;
		idle_cnt_d = idle_cnt_q;
		ext_osc_d = ext_osc_q;
		ext_sck_d = ext_sck_q;
		loaded_d = loaded_q;
		rise_cnt_d = rise_cnt_q;
		isck_cnt_d = isck_cnt_q;
		shift_d = shift_q;
		cfg_sr_d = cfg_sr_q;
		cfg_d = cfg_q;
		sck_d = sck_q;
		fifo_in_valid = 1'b0;
		fifo_out_ready = 1'b0;
		conv_tick = 1'b0;
		sck_rise = 1'b0;
		sck_fall = 1'b0;

		// external conversion clock takes over while f0 keeps toggling
		if (f0_rise) begin
			ext_osc_d = 1'b1;
			idle_cnt_d = '0;
		end else if (idle_cnt_q == 12'(OSC_IDLE_CYCLES - 1)) begin
			ext_osc_d = 1'b0;
		end else begin
			idle_cnt_d = idle_cnt_q + 12'h001;
		end
		if (osc_cnt_q == 12'(INT_OSC_DIV - 1)) begin
			osc_cnt_d = '0;
			conv_tick = !ext_osc_q;
		end else begin
			osc_cnt_d = osc_cnt_q + 12'h001;
		end
		if (ext_osc_q && f0_rise) begin
			conv_tick = 1'b1;
		end

		// serial clock events, from the pin or from our own divider
		if (st_q == ST_IO && ext_sck_q) begin
			sck_rise = sck_s && !sck_p;
			sck_fall = !sck_s && sck_p;
		end else if (st_q == ST_IO && !cs_n_s) begin
			if (isck_cnt_q == 5'(ISCK_HALF_CYCLES - 1)) begin
				isck_cnt_d = '0;
				sck_d = !sck_q;
				sck_rise = !sck_q;
				sck_fall = sck_q;
			end else begin
				isck_cnt_d = isck_cnt_q + 5'h01;
			end
		end else begin
			isck_cnt_d = '0;
			sck_d = 1'b1;
		end

		// mode follows the clock level at every select fall
		if (cs_fall) begin
			ext_sck_d = !sck_s;
		end

		case (st_q)
			ST_POR: begin
				cfg_d = CFG_DEFAULT;
				cfg_sr_d = '0;
				shift_d = '0;
				loaded_d = 1'b0;
				if (por_cnt_q == 20'(POR_CYCLES_P - 1)) begin
					st_d = ST_CONV;
					conv_cnt_d = '0;
					ext_sck_d = !sck_s;
				end else begin
					por_cnt_d = por_cnt_q + 20'h00001;
				end
			end
			ST_CONV: begin
				// the finished word waits for fifo room, stalling the cycle
				if (conv_cnt_q == 16'(CONV_TICKS_P)) begin
					fifo_in_valid = 1'b1;
					if (fifo_in_ready) begin
						st_d = ST_SLEEP;
						loaded_d = 1'b0;
					end
				end else if (conv_tick) begin
					conv_cnt_d = conv_cnt_q + 16'h0001;
				end
			end
			ST_SLEEP: begin
				fifo_out_ready = !loaded_q;
				if (fifo_out_valid && !loaded_q) begin
					shift_d = fifo_data;
					loaded_d = 1'b1;
				end
				if (loaded_q && !cs_n_s) begin
					st_d = ST_IO;
					rise_cnt_d = '0;
				end
			end
			ST_IO: begin
				if (cs_rise) begin
					if (rise_cnt_q == '0) begin
						st_d = ST_SLEEP;
					end else begin
						st_d = ST_CONV;
						conv_cnt_d = '0;
						if (rise_cnt_q >= 6'(CFG_BITS)) begin
							cfg_d = cfg_sr_q;
						end
					end
				end else if (sck_rise) begin
					if (rise_cnt_q < 6'(CFG_BITS)) begin
						cfg_sr_d = {cfg_sr_q[CFG_BITS-2:0], sdi_s};
					end
					rise_cnt_d = rise_cnt_q + 6'h01;
				end else if (sck_fall && rise_cnt_q != '0) begin
					if (rise_cnt_q == 6'(OUT_BITS)) begin
						st_d = ST_CONV;
						conv_cnt_d = '0;
						cfg_d = cfg_sr_q;
					end else begin
						shift_d = {shift_q[OUT_BITS-2:0], 1'b0};
					end
				end
			end
			default: begin
				st_d = ST_POR;
			end
		endcase

		if (sup_s) begin
			st_d = ST_POR;
			por_cnt_d = '0;
		end

		// only status leaves the pin outside the transfer
		case (st_d)
			ST_CONV: sdo_d = 1'b1;
			ST_IO:   sdo_d = shift_d[OUT_BITS-1];
			default: sdo_d = 1'b0;
		endcase
		sdo_oe_d = !cs_n_s && st_d != ST_POR;
		// the closing fall must reach the pin before the driver lets go
		sck_oe_d = !ext_sck_d && (st_d == ST_IO
			|| (st_q == ST_IO && st_d == ST_CONV && sck_fall && !cs_rise));

		// calibration is folded into the count, cycle unchanged
		if (conv_cnt_q < 16'(CONV_TICKS_P / 4)) begin
			phase_d = PH_OFFSET;
		end else if (conv_cnt_q < 16'(CONV_TICKS_P / 2)) begin
			phase_d = PH_FULLSCALE;
		end else begin
			phase_d = PH_SIGNAL;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_q <= ST_POR;
			por_cnt_q <= '0;
			conv_cnt_q <= '0;
			osc_cnt_q <= '0;
			idle_cnt_q <= '0;
			ext_osc_q <= 1'b0;
			ext_sck_q <= 1'b0;
			loaded_q <= 1'b0;
			rise_cnt_q <= '0;
			isck_cnt_q <= '0;
			shift_q <= '0;
			cfg_sr_q <= '0;
			cfg_q <= CFG_DEFAULT;
			sck_q <= 1'b1;
			sck_oe_q <= 1'b0;
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
			phase_q <= PH_OFFSET;
		end else begin
			st_q <= st_d;
			por_cnt_q <= por_cnt_d;
			conv_cnt_q <= conv_cnt_d;
			osc_cnt_q <= osc_cnt_d;
			idle_cnt_q <= idle_cnt_d;
			ext_osc_q <= ext_osc_d;
			ext_sck_q <= ext_sck_d;
			loaded_q <= loaded_d;
			rise_cnt_q <= rise_cnt_d;
			isck_cnt_q <= isck_cnt_d;
			shift_q <= shift_d;
			cfg_sr_q <= cfg_sr_d;
			cfg_q <= cfg_d;
			sck_q <= sck_d;
			sck_oe_q <= sck_oe_d;
			sdo_q <= sdo_d;
			sdo_oe_q <= sdo_oe_d;
			phase_q <= phase_d;
		end
	end

	assign sck_out       = sck_q;
	assign sck_oe_out    = sck_oe_q;
	assign sdo_out       = sdo_q;
	assign sdo_oe_out    = sdo_oe_q;
	assign afe_cfg_out   = cfg_q;
	assign afe_phase_out = phase_q;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	conv_end_sleep_a: assert property (st_q == ST_CONV && fifo_in_valid && fifo_in_ready && !sup_s
		|=> st_q == ST_SLEEP) else $error("finished conversion did not sleep");
	sleep_hold_a: assert property (st_q == ST_SLEEP && loaded_q && cs_n_s && !sup_s
		|=> $stable(shift_q)) else $error("held result changed in sleep");
	wake_io_a: assert property (st_q == ST_SLEEP && loaded_q && !cs_n_s && !sup_s
		|=> st_q == ST_IO && sdo_out == shift_q[OUT_BITS-1]) else $error("select low did not wake");
	abort_sleep_a: assert property (st_q == ST_IO && cs_rise && rise_cnt_q == '0 && !sup_s
		|=> st_q == ST_SLEEP) else $error("early abort did not return to sleep");
	abort_conv_a: assert property (st_q == ST_IO && cs_rise && rise_cnt_q != '0 && !sup_s
		|=> st_q == ST_CONV ##1 sdo_out) else $error("abort did not start conversion");
	fall_shift_a: assert property (st_q == ST_IO && !cs_rise && sck_fall && rise_cnt_q != '0
		&& rise_cnt_q != 6'(OUT_BITS) && !sup_s |=> sdo_out == $past(shift_q[OUT_BITS-2]))
		else $error("output bit not advanced on falling edge");
	sdi_take_a: assert property (st_q == ST_IO && sck_rise && !cs_rise && rise_cnt_q < 6'(CFG_BITS)
		&& !sup_s |=> cfg_sr_q[0] == $past(sdi_s)) else $error("input bit not captured");
	word_done_a: assert property (st_q == ST_IO && sck_fall && !cs_rise && rise_cnt_q == 6'(OUT_BITS)
		&& !sup_s |=> st_q == ST_CONV && afe_cfg_out == $past(cfg_sr_q)) else $error("word end mishandled");
	part_cfg_a: assert property (st_q == ST_IO && cs_rise && rise_cnt_q < 6'(CFG_BITS) && !sup_s
		|=> $stable(afe_cfg_out)) else $error("partial configuration applied");
	busy_sdo_a: assert property (st_q == ST_CONV && !fifo_in_valid && !cs_n_s && !sup_s
		|=> sdo_out && sdo_oe_out) else $error("busy status not shown");
	release_sdo_a: assert property (cs_n_s |=> !sdo_oe_out) else $error("output driven with select high");
	por_cfg_a: assert property (st_q == ST_POR |=> afe_cfg_out == CFG_DEFAULT)
		else $error("reset configuration not default");
	mode_pick_a: assert property (cs_fall |=> ext_sck_q != $past(sck_s))
		else $error("clock mode not taken at select fall");
	supply_hold_a: assert property (sup_s |=> st_q == ST_POR) else $error("low supply did not hold reset");

endmodule // adcseq_top

// File: tb/adcseq_host_model.sv
// host model for the serial pins: select, serial clock, config bits, word capture
// assumes the bench resolves the sck wire with a pull-up and pulses start_in
module adcseq_host_model
	import adcseq_pkg::*;
(
	// control from the bench
	input  wire logic                clk_in,
	input  wire logic                start_in,
	input  wire logic                ext_in,
	input  wire logic [5:0]          nbits_in,
	input  wire logic [CFG_BITS-1:0] cfg_in,
	// serial pins
	input  wire logic                sck_wire_in,
	input  wire logic                sdo_in,
	output logic                     cs_n_out,
	output logic                     sck_out,
	output logic                     sck_oe_out,
	output logic                     sdi_out,
	// results
	output logic                     stat_out,
	output logic                     done_out,
	output logic [OUT_BITS-1:0]      rx_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [CFG_BITS-1:0] sr;
	logic                go;
	int                  k;
	int                  t;

	// ********************
	// transfer sequencing
	// ********************
	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask

	task automatic wait_lvl(input logic v);
		for (t = 0; t < 100 && sck_wire_in !== v; t++) tick();
	endtask

	// one half period: own clock when external, follow the wire when internal
	task automatic half(input logic v);
		if (ext_in) begin
			repeat (ISCK_HALF_CYCLES) tick();
			sck_out = v;
		end else wait_lvl(v);
	endtask

	task automatic run();
		cs_n_out = 1'b0;
		sck_oe_out = ext_in;
		sck_out = 1'b0;
		sr = cfg_in;
		sdi_out = sr[CFG_BITS-1];
		rx_out = '0;
		repeat (8) tick();
		stat_out = sdo_in;
		for (t = 0; t < 3000 && sdo_in !== 1'b0; t++) tick();
		for (k = 0; k < nbits_in; k++) begin
			if (k > 0 || !ext_in) half(1'b0);
			if (k > 0) begin
				// past the word the line keeps toggling, no kinder than a real host
				sr = {sr[CFG_BITS-2:0], ~sdi_out};
				sdi_out = sr[CFG_BITS-1];
			end
			half(1'b1);
			rx_out = {rx_out[OUT_BITS-2:0], sdo_in};
		end
		if (nbits_in == OUT_BITS) half(1'b0);
		repeat (10) tick();
		cs_n_out = 1'b1;
		repeat (6) tick();
		sck_out = 1'b0;
		sck_oe_out = 1'b1;
		done_out = 1'b1;
	endtask

	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		sck_oe_out = 1'b1;
		sdi_out = 1'b0;
		stat_out = 1'b0;
		done_out = 1'b0;
		rx_out = '0;
	end

	always begin
		@(posedge clk_in);
		go = start_in;
		#1;
		done_out = 1'b0;
		if (go) run();
		else sdi_out = ~sdi_out;
	end
endmodule // adcseq_host_model

// File: tb/adcseq_top_tb.sv
// bench for the converter cycle sequencer with a host model; the fifo is exercised through the top
// assumes the package and design files are compiled first
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end
module adcseq_top_tb
	import adcseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                         clk_in, srst_in, f0, supply_low, afe_sign, afe_over, afe_under;
	logic [RES_BITS+SUB_BITS-1:0] afe_value;
	logic                         start, ext, sck_wire, cs_n, h_sck, h_sck_oe, sdi, stat, done;
	logic                         sck_out, sck_oe_out, sdo_out, sdo_oe_out;
	logic [5:0]                   nbits;
	logic [CFG_BITS-1:0]          cfg, cfg_now, afe_cfg_out;
	logic [1:0]                   afe_phase_out;
	logic [OUT_BITS-1:0]          rx, cur;
	logic [OUT_BITS:0]            e;
	logic [OUT_BITS:0]            q[$];
	int                           seed = 32'h42c2;
	int                           miscompares = 0;
	int                           comparisons = 0;
	int                           t, i;

	// ********************
	// clocks and instances
	// ********************
	always #2 clk_in = ~clk_in;
	// conversion clock from outside keeps each conversion short
	always #40 f0 = ~f0;
	assign sck_wire = h_sck_oe ? h_sck : (sck_oe_out ? sck_out : 1'b1);

	adcseq_top #(.POR_CYCLES_P(20), .CONV_TICKS_P(8)) dut (.clk_in(clk_in), .srst_in(srst_in),
		.cs_n_in(cs_n), .sck_in(sck_wire), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .sdi_in(sdi),
		.sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .conversion_clock_select_in(f0),
		.supply_low_in(supply_low), .afe_sign_in(afe_sign), .afe_value_in(afe_value),
		.afe_over_in(afe_over), .afe_under_in(afe_under), .afe_cfg_out(afe_cfg_out),
		.afe_phase_out(afe_phase_out));
	// a released sdo shows the inverse of its last value, so a late driver is caught
	adcseq_host_model host (.clk_in(clk_in), .start_in(start), .ext_in(ext), .nbits_in(nbits),
		.cfg_in(cfg), .sck_wire_in(sck_wire), .sdo_in(sdo_oe_out ? sdo_out : ~sdo_out), .cs_n_out(cs_n),
		.sck_out(h_sck), .sck_oe_out(h_sck_oe), .sdi_out(sdi), .stat_out(stat), .done_out(done), .rx_out(rx));

	// ********************
	// tasks
	// ********************
	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask

	task automatic set_afe(input int mode);
		afe_sign = 1'($random(seed));
		afe_value = (RES_BITS+SUB_BITS)'($random(seed));
		afe_over = (mode == 1);
		afe_under = (mode == 2);
		cur = afe_over ? WORD_OVER : (afe_under ? WORD_UNDER : {EOC_DONE, CONSTANT_ZERO_BIT, afe_sign, afe_value});
	endtask

	// reads nb bits; the front end then gets values for the conversion just started
	task automatic xfer(input int nb, input logic e_mode, input logic st, input int mode);
		q.push_back({st, cur >> (OUT_BITS - nb)});
		cfg = CFG_BITS'($random(seed));
		ext = e_mode;
		nbits = nb[5:0];
		start = 1'b1;
		tick();
		start = 1'b0;
		for (t = 0; t < 6000 && done !== 1'b1; t++) @(posedge clk_in);
		if (done !== 1'b1) miscompares++;
		tick();
		if (nb >= CFG_BITS) cfg_now = cfg;
		`CHK(afe_cfg_out, cfg_now)
		if (nb > 0) set_afe(mode);
	endtask

	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ********************
	// checks and sequence
	// ********************
	always @(posedge clk_in) begin
		if (done === 1'b1) begin
			e = q.pop_front();
			`CHK({stat, rx}, e)
			`CHK(sdo_oe_out, 1'b0)
			`CHK(sck_oe_out, 1'b0)
			`CHK(sck_out, 1'b1)
		end
	end

	initial begin
		#120000;
		miscompares++;
		end_sim();
	end

	initial begin
		clk_in = 1'b0;
		srst_in = 1'b1;
		f0 = 1'b0;
		supply_low = 1'b0;
		{start, ext, nbits, cfg} = '0;
		cfg_now = CFG_DEFAULT;
		set_afe(0);
		repeat (16) @(posedge clk_in);
		#1;
		srst_in = 1'b0;
		repeat (30) tick();
		`CHK(afe_cfg_out, CFG_DEFAULT)
		`CHK(afe_phase_out, PH_OFFSET)
		xfer(32, 1'b1, 1'b1, 0);
		xfer(0, 1'b1, 1'b1, 0);
		xfer(12, 1'b1, 1'b0, 1);
		xfer(13, 1'b1, 1'b1, 2);
		xfer(32, 1'b0, 1'b1, 0);
		for (i = 0; i < 4; i++) xfer(32, i[0], 1'b1, 0);
		supply_low = 1'b1;
		repeat (10) tick();
		supply_low = 1'b0;
		repeat (5) tick();
		cfg_now = CFG_DEFAULT;
		`CHK(afe_cfg_out, CFG_DEFAULT)
		repeat (30) tick();
		xfer(32, 1'b1, 1'b1, 0);
		end_sim();
	end
endmodule // adcseq_top_tb
